// *** verilog/ssp_pkg.sv ***
package ssp_pkg;
  // Register word addresses (byte address / 4), two instances side by side
  localparam logic [3:0] ADDR_STATUS_0  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_0 = 4'h1;
  localparam logic [3:0] ADDR_BUFFER_0  = 4'h2;
  localparam logic [3:0] ADDR_STATUS_1  = 4'h4;
  localparam logic [3:0] ADDR_CONTROL_1 = 4'h5;
  localparam logic [3:0] ADDR_BUFFER_1  = 4'h6;
  // Status fields
  localparam int STAT_SMP  = 7;
  localparam int STAT_CKE  = 6;
  localparam int STAT_STOP = 4;
  localparam int STAT_BF   = 0;
  // Control fields
  localparam int CTL_WRITE_COLLISION = 7;
  localparam int CTL_OV   = 6;
  localparam int CTL_EN   = 5;
  localparam int CTL_CKP  = 4;
  // Reset values
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Mode field codes
  localparam logic [3:0] MODE_M_DIV4  = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TMR   = 4'h3;
  localparam logic [3:0] MODE_S_SS    = 4'h4;
  localparam logic [3:0] MODE_S_NOSS  = 4'h5;
  // Half-period of serial clock in system clocks for each master rate
  localparam logic [4:0] HALF_DIV4  = 5'h02;
  localparam logic [4:0] HALF_DIV16 = 5'h08;
  localparam logic [4:0] HALF_DIV64 = 5'h20;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
endpackage

// *** verilog/ssp_spi.sv ***
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
// Overview of operation
// - Eight bits shift out and in together
// - All four polarity and phase modes supported
// - Two independent instances, separate registers, pins
// - Shift register reachable only through buffer
// - Status low six read-only, top two writable
// - Complete byte goes to buffer, flag set
// - Buffer write loads buffer and shifter together
// - Overflow sets, new byte discarded if unread
// - Overflow only in slave role; software clears
// - Enable hands pins to port, else GPIO
// - Idle clock level follows polarity bit
// - Mode codes 0101/0100 choose slave, select control
// - Edge bit set: data valid before first edge
// - Buffer-full sets on load, clears on read
// - Write during transfer ignored, collision flag set
// - Master clock sys/4, /16, /64 or timer/2

// One serial port engine with its own three registers
module ssp_spi_core (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       sel_status,
  input  wire logic       sel_control,
  input  wire logic       sel_buffer,
  input  wire logic       wr,
  input  wire logic       rd_strobe,
  input  wire logic [7:0] wdata,
  output logic      [7:0] status_o,
  output logic      [7:0] control_o,
  output logic      [7:0] buffer_o,
  input  wire logic       timer_tick,
  input  wire logic       sck_in,
  input  wire logic       sdi_in,
  input  wire logic       ss_n_in,
  output logic            sck_out,
  output logic            sck_oe,
  output logic            sdo_out,
  output logic            sdo_oe,
  output logic            port_owns_pins,
  output logic            irq_flag
);
  typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_state_e;

  logic [7:0] status_q, control_q, buf_q, shift_q;
  logic [3:0] bits_q;
  logic [4:0] div_q;
  logic       sck_q, sdo_q, pend_q, flag_q;
  logic [1:0] sck_sync_q, sdi_sync_q, ss_sync_q;
  logic       sck_prev_q;
  ssp_state_e state_q;

  wire [3:0] mode     = control_q[3:0];
  wire       en       = control_q[ssp_pkg::CTL_EN];
  wire       clock_idle_polarity      = control_q[ssp_pkg::CTL_CKP];
  wire       cke      = status_q[ssp_pkg::STAT_CKE];
  wire       sample_phase      = status_q[ssp_pkg::STAT_SMP];
  wire       slave    = (mode == ssp_pkg::MODE_S_SS) || (mode == ssp_pkg::MODE_S_NOSS);
  wire       use_ss   = (mode == ssp_pkg::MODE_S_SS);
  wire       ss_ok    = !use_ss || !ss_sync_q[1];
  wire       busy     = (state_q != SSP_IDLE);
  wire       buf_wr   = sel_buffer && wr;
  wire       buf_rd   = sel_buffer && rd_strobe;
  wire       sck_s    = sck_sync_q[1];
  // Slave edges on synchronised clock; polarity removed so lead is idle-to-active
  wire       sck_act  = sck_s ^ clock_idle_polarity;
  wire       s_lead   = slave && en && ss_ok && sck_act && !(sck_prev_q ^ clock_idle_polarity);
  wire       s_trail  = slave && en && ss_ok && !sck_act && (sck_prev_q ^ clock_idle_polarity);

  // Half-period length for the master rate
  function automatic logic [4:0] half_len(input logic [3:0] m);
    case (m)
      ssp_pkg::MODE_M_DIV16: half_len = ssp_pkg::HALF_DIV16;
      ssp_pkg::MODE_M_DIV64: half_len = ssp_pkg::HALF_DIV64;
      default:               half_len = ssp_pkg::HALF_DIV4;
    endcase
  endfunction

  // Master half-period tick; timer mode toggles per timer tick, halving it
  wire m_tick = (mode == ssp_pkg::MODE_M_TMR) ? timer_tick
              : (div_q == half_len(mode) - 5'h01);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_q <= 5'h00;
    end else if (!busy || m_tick || mode == ssp_pkg::MODE_M_TMR) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // Pin input synchronisers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_sync_q <= 2'b00;
      sdi_sync_q <= 2'b00;
      ss_sync_q  <= 2'b11;
      sck_prev_q <= 1'b0;
    end else begin
      sck_sync_q <= {sck_sync_q[0], sck_in};
      sdi_sync_q <= {sdi_sync_q[0], sdi_in};
      ss_sync_q  <= {ss_sync_q[0], ss_n_in};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  // Edge events: lead = idle-to-active, trail = active-to-idle
  wire lead_ev  = slave ? s_lead  : (state_q == SSP_LEAD  && m_tick);
  wire trail_ev = slave ? s_trail : (state_q == SSP_TRAIL && m_tick);
  // Shift out on trailing edge when edge bit set, else on lead edge
  wire out_ev   = cke ? trail_ev : lead_ev;
  wire in_ev    = cke ? lead_ev : trail_ev;
  // Master with sample bit set samples at end of bit, i.e. one edge later
  wire samp_ev  = (!slave && sample_phase) ? out_ev : in_ev;
  wire last_bit = (bits_q == ssp_pkg::BITS_PER_XFER - 4'h1);
  // Master takes its input bit one clock after the sample event: data in
  // passes two flops, so at the fastest rate the bit would not yet have
  // reached the second flop on the event itself
  logic samp_late_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      samp_late_q <= 1'b0;
    end else begin
      samp_late_q <= en && busy && !slave && samp_ev;
    end
  end
  // Slave edges already come through the same two flops as its data
  wire shift_now = slave ? samp_ev : samp_late_q;
  wire done     = busy && shift_now && last_bit;

  // Transfer sequencer and shifter, MSB first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= SSP_IDLE;
      shift_q <= 8'h00;
      bits_q  <= 4'h0;
      sdo_q   <= 1'b0;
      sck_q   <= 1'b0;
    end else if (!en) begin
      state_q <= SSP_IDLE;
      bits_q  <= 4'h0;
      sck_q   <= clock_idle_polarity;
    end else begin
      case (state_q)
        SSP_IDLE: begin
          sck_q <= clock_idle_polarity;
          if (buf_wr) begin
            shift_q <= wdata;
            bits_q  <= 4'h0;
            sdo_q   <= wdata[7];
            state_q <= SSP_LEAD;
          end
        end
        SSP_LEAD, SSP_TRAIL: begin
          if (!slave && m_tick) begin
            sck_q   <= (state_q == SSP_LEAD) ? !clock_idle_polarity : clock_idle_polarity;
            state_q <= (state_q == SSP_LEAD) ? SSP_TRAIL : SSP_LEAD;
          end
          if (shift_now) begin
            shift_q <= {shift_q[6:0], sdi_sync_q[1]};
            bits_q  <= bits_q + 4'h1;
          end
          // Without edge bit the first bit already stands; later bits follow
          if (out_ev && !(cke == 1'b0 && bits_q == 4'h0 && !samp_ev))
            sdo_q <= samp_ev ? shift_q[6] : shift_q[7];
          if (done) begin
            state_q <= SSP_IDLE;
            sck_q   <= clock_idle_polarity;
          end
        end
        default: state_q <= SSP_IDLE;
      endcase
    end
  end

  // Slave: shift edges come from the peer, so sequencer idles between bytes
  // only by count; a write while a byte is in progress (busy) is a collision below.

  // Receive buffer, buffer-full, flag and overflow
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      buf_q  <= 8'h00;
      pend_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      if (done && !(pend_q && slave)) begin
        buf_q <= {shift_q[6:0], sdi_sync_q[1]};
      end else if (buf_wr && !busy) begin
        buf_q <= wdata;
      end
      if (done) begin
        pend_q <= 1'b1; // set wins over read
        flag_q <= 1'b1;
      end else if (buf_rd) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Control register: collision and overflow are sticky, set beats clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_q <= ssp_pkg::CONTROL_RESET;
    end else begin
      if (sel_control && wr) control_q <= wdata;
      if (buf_wr && busy) control_q[ssp_pkg::CTL_WRITE_COLLISION] <= 1'b1;
      if (done && pend_q && slave) control_q[ssp_pkg::CTL_OV] <= 1'b1;
    end
  end

  // Status: only the top two bits take writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_q <= ssp_pkg::STATUS_RESET;
    end else begin
      if (sel_status && wr) status_q[7:6] <= wdata[7:6];
      if (!en) status_q[ssp_pkg::STAT_STOP] <= 1'b0;
      status_q[ssp_pkg::STAT_BF] <= pend_q;
    end
  end

  // Pins: enable hands them over; slave in mode 0100 with select high floats data out
  assign port_owns_pins = en;
  assign sck_out  = sck_q;
  assign sck_oe   = en && !slave;
  assign sdo_out  = sdo_q;
  assign sdo_oe   = en && ss_ok;
  assign irq_flag = flag_q;
  assign status_o = {status_q[7:1], pend_q};
  assign control_o = control_q;
  assign buffer_o = buf_q;

  // Checks
  chk_bf_on_done: assert property (@(posedge clock) disable iff (!resetn)
    done |=> pend_q) else $error("buffer full not set after byte");
  chk_write_collision_busy: assert property (@(posedge clock) disable iff (!resetn)
    (buf_wr && busy) |=> control_q[ssp_pkg::CTL_WRITE_COLLISION]) else $error("collision missed");
  chk_ov_master: assert property (@(posedge clock) disable iff (!resetn)
    (!slave && !(sel_control && wr)) |=> !$rose(control_q[ssp_pkg::CTL_OV]))
    else $error("overflow in master role");
  chk_idle_level: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == SSP_IDLE && en) |=> (sck_q == $past(clock_idle_polarity)) || busy)
    else $error("idle clock level wrong");
  chk_load_shift: assert property (@(posedge clock) disable iff (!resetn)
    (buf_wr && !busy && en) |=> (shift_q == buf_q) && busy)
    else $error("write did not load both");
  chk_stop_clear: assert property (@(posedge clock) disable iff (!resetn)
    !en |=> !status_q[ssp_pkg::STAT_STOP]) else $error("stop bit not cleared");
  chk_sdo_first: assert property (@(posedge clock) disable iff (!resetn)
    (buf_wr && !busy && en) |=> sdo_q == $past(wdata[7])) else $error("msb not first");
  chk_ov_keep: assert property (@(posedge clock) disable iff (!resetn)
    (done && pend_q && slave) |=> $stable(buf_q)) else $error("overflow byte kept");
endmodule // ssp_spi_core

// Two independent ports behind one Avalon-MM slave
module ssp_spi (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [3:0] address,
  input  wire logic       read,
  input  wire logic       write,
  input  wire logic [31:0] writedata,
  output logic     [31:0] readdata,
  output logic            waitrequest,
  input  wire logic [1:0] timer_tick,
  input  wire logic [1:0] sck_in,
  input  wire logic [1:0] sdi_in,
  input  wire logic [1:0] ss_n_in,
  output logic      [1:0] sck_out,
  output logic      [1:0] sck_oe,
  output logic      [1:0] sdo_out,
  output logic      [1:0] sdo_oe,
  output logic      [1:0] port_owns_pins,
  output logic      [1:0] port_interrupt_flag
);
  logic [7:0] st [2], ct [2], bf [2];
  logic       ack_q;
  logic [31:0] rdata_q;

  // One wait state: request is taken on the edge where waitrequest is low
  assign waitrequest = (read || write) && !ack_q;
  wire take = (read || write) && ack_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) ack_q <= 1'b0;
    else         ack_q <= (read || write) && !ack_q;
  end

  // Independent instances, each its own registers and pins
  for (genvar i = 0; i < 2; i++) begin : g_port
    wire [3:0] base = (i == 0) ? ssp_pkg::ADDR_STATUS_0 : ssp_pkg::ADDR_STATUS_1;
    ssp_spi_core u_core (
      .clock          (clock),
      .resetn         (resetn),
      .sel_status     (address == base),
      .sel_control    (address == base + 4'h1),
      .sel_buffer     (address == base + 4'h2),
      .wr             (take && write),
      .rd_strobe      (take && read),
      .wdata          (writedata[7:0]),
      .status_o       (st[i]),
      .control_o      (ct[i]),
      .buffer_o       (bf[i]),
      .timer_tick     (timer_tick[i]),
      .sck_in         (sck_in[i]),
      .sdi_in         (sdi_in[i]),
      .ss_n_in        (ss_n_in[i]),
      .sck_out        (sck_out[i]),
      .sck_oe         (sck_oe[i]),
      .sdo_out        (sdo_out[i]),
      .sdo_oe         (sdo_oe[i]),
      .port_owns_pins (port_owns_pins[i]),
      .irq_flag       (port_interrupt_flag[i])
    );
  end

  // Read mux; unmapped words read zero
  always_comb begin
    case (address)
      ssp_pkg::ADDR_STATUS_0:  readdata = {24'h000000, st[0]};
      ssp_pkg::ADDR_CONTROL_0: readdata = {24'h000000, ct[0]};
      ssp_pkg::ADDR_BUFFER_0:  readdata = {24'h000000, bf[0]};
      ssp_pkg::ADDR_STATUS_1:  readdata = {24'h000000, st[1]};
      ssp_pkg::ADDR_CONTROL_1: readdata = {24'h000000, ct[1]};
      ssp_pkg::ADDR_BUFFER_1:  readdata = {24'h000000, bf[1]};
      default:                 readdata = 32'h00000000;
    endcase
  end
endmodule // ssp_spi

// *** tb/ssp_spi_peer.sv ***
`timescale 1ns/1ns
// Behavioural SPI slave on the far side of a master port, clock idle low
module ssp_spi_peer (
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            sdi,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh_q;
  int         n_bits;

  initial begin
    sdi     = 1'b0;
    rx_byte = 8'h00;
    n_bits  = 8;
  end

  // Arm: first bit stands before the first clock edge
  always @(posedge load) begin
    sh_q   = tx_byte;
    sdi    = tx_byte[7];
    n_bits = 0;
  end

  // Capture on the active edge, MSB arrives first
  always @(posedge sck) begin
    rx_byte = {rx_byte[6:0], sdo};
    n_bits  = n_bits + 1;
  end

  // Shift on the idle edge; after the byte the line shows no stale bit
  always @(negedge sck) begin
    sh_q = {sh_q[6:0], 1'b0};
    if (n_bits < 8) begin
      sdi = sh_q[7];
    end else begin
      sdi = ~sdi;
    end
  end
endmodule // ssp_spi_peer

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
// Self-checking bench: Avalon master, peer slave on port 0
module tb_top;
  logic        clock       = 1'b0;
  logic        resetn      = 1'b0;
  logic [3:0]  address     = 4'h0;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  timer_tick  = 2'h0;
  logic [1:0]  tick_cnt    = 2'h0;
  logic [1:0]  sck_out, sck_oe, sdo_out, sdo_oe, port_owns_pins, port_interrupt_flag;
  logic        sck_w, peer_sdi, peer_load;
  logic [7:0]  peer_tx, peer_rx;
  logic [31:0] rd;
  int          mismatches  = 0;
  int          n_checks    = 0;

  always #5 clock = ~clock;
  assign sck_w = sck_oe[0] ? sck_out[0] : 1'b0;

  // Period timer stand-in: one pulse every 4 cycles
  always @(posedge clock) begin
    tick_cnt   <= tick_cnt + 2'h1;
    timer_tick <= {2{tick_cnt == 2'h3}};
  end

  ssp_spi ssp_spi_i (
    .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timer_tick(timer_tick), .sck_in({1'b0, sck_w}), .sdi_in({1'b0, peer_sdi}),
    .ss_n_in(2'h3), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .port_owns_pins(port_owns_pins),
    .port_interrupt_flag(port_interrupt_flag));

  ssp_spi_peer ssp_spi_peer_i (
    .sck(sck_w), .sdo(sdo_out[0]), .load(peer_load), .tx_byte(peer_tx),
    .sdi(peer_sdi), .rx_byte(peer_rx));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    write     <= we;
    read      <= ~we;
    address   <= a;
    writedata <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      mismatches++;
      $display("[FAIL] bus answer expected 0 seen %b", waitrequest);
    end
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clock);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_reset;
    bus(1'b0, ssp_pkg::ADDR_STATUS_0, 8'h00);
    check("status0 reset", rd, {24'h0, ssp_pkg::STATUS_RESET});
    bus(1'b0, ssp_pkg::ADDR_CONTROL_1, 8'h00);
    check("control1 reset", rd, {24'h0, ssp_pkg::CONTROL_RESET});
    $display("test reset done");
  endtask

  // Access kinds, port independence, unmapped write has no effect
  task automatic t_regs;
    bus(1'b1, ssp_pkg::ADDR_CONTROL_0, 8'h15);
    bus(1'b1, 4'h3, 8'hFF);
    bus(1'b0, ssp_pkg::ADDR_CONTROL_0, 8'h00);
    check("control0 rw", rd, 32'h15);
    bus(1'b1, ssp_pkg::ADDR_STATUS_0, 8'hFF);
    bus(1'b0, ssp_pkg::ADDR_STATUS_0, 8'h00);
    check("status0 ro low", rd, 32'hC0);
    bus(1'b0, ssp_pkg::ADDR_CONTROL_1, 8'h00);
    check("control1 apart", rd, 32'h00);
    bus(1'b1, ssp_pkg::ADDR_CONTROL_0, 8'h00);
    bus(1'b1, ssp_pkg::ADDR_STATUS_0, 8'h00);
    $display("test regs done");
  endtask

  // Master transfer at every rate, with a colliding write mid-transfer
  task automatic t_xfer;
    int k;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ssp_pkg::ADDR_STATUS_0, 8'h40);
      bus(1'b1, ssp_pkg::ADDR_CONTROL_0, 8'h20 | m[7:0]);
      check("owns pins", port_owns_pins, 32'h1);
      check("data out driven", sdo_oe, 32'h1);
      check("idle clock low", sck_out[0], 32'h0);
      peer_tx   <= 8'h5A ^ m[7:0];
      peer_load <= 1'b1;
      bus(1'b1, ssp_pkg::ADDR_BUFFER_0, 8'hA3 + m[7:0]);
      peer_load <= 1'b0;
      bus(1'b1, ssp_pkg::ADDR_BUFFER_0, 8'h11);
      bus(1'b0, ssp_pkg::ADDR_CONTROL_0, 8'h00);
      check("collision flag", rd, 32'hA0 | m);
      k = 0;
      do begin
        bus(1'b0, ssp_pkg::ADDR_STATUS_0, 8'h00);
        k++;
      end while (rd[0] !== 1'b1 && k < 400);
      check("buffer full", rd[0], 32'h1);
      check("port flag", port_interrupt_flag[0], 32'h1);
      bus(1'b0, ssp_pkg::ADDR_BUFFER_0, 8'h00);
      check("rx byte", rd, {24'h0, 8'h5A ^ m[7:0]});
      check("tx byte", peer_rx, {24'h0, 8'hA3 + m[7:0]});
      bus(1'b0, ssp_pkg::ADDR_STATUS_0, 8'h00);
      check("full cleared", rd, 32'h40);
      bus(1'b1, ssp_pkg::ADDR_CONTROL_0, 8'h00);
      check("pins released", port_owns_pins, 32'h0);
      bus(1'b0, ssp_pkg::ADDR_STATUS_0, 8'h00);
      check("stop cleared", rd, 32'h40);
    end
    bus(1'b1, ssp_pkg::ADDR_CONTROL_0, 8'h30);
    repeat (4) @(posedge clock);
    check("idle clock high", sck_out[0], 32'h1);
    bus(1'b1, ssp_pkg::ADDR_CONTROL_0, 8'h00);
    $display("test transfer done");
  endtask

  // Watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #300000;
    mismatches++;
    give_verdict();
  end

  initial begin
    peer_load = 1'b0;
    peer_tx   = 8'h00;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_regs();
    t_xfer();
    give_verdict();
  end
endmodule // tb_top
